/* rtl/sscw_link.sv */
// Serial link shifter running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module sscw_link
	import sscw_pkg::*;
(
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic [WORD_W-1:0] status_word,
	output logic serial_out,
	output logic [WORD_W-1:0] rx_word
);
	logic [4:0] rcnt_r;
	logic [4:0] ocnt_r;

	// Receive shift, sampled on rising edge, LSB enters first
	always_ff @(posedge sclk)
	begin
		rx_word <= {serial_in, rx_word[WORD_W-1:1]};
	end

	// Bits taken this frame, cleared while deselected
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
			rcnt_r <= '0;
		else if (rcnt_r != BIT_CNT_FULL)
			rcnt_r <= 5'(rcnt_r + 5'h01);
	end

	// Output index advances on falling edge
	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
			ocnt_r <= '0;
		else
			ocnt_r <= rcnt_r;
	end

	// Status first, then incoming bits pass on for a chain
	assign serial_out = ocnt_r[4] ? rx_word[0] : status_word[ocnt_r[3:0]];
endmodule : sscw_link
`default_nettype wire

/* rtl/sscw_pkg.sv */
// Constants, bit positions and types of the supply serial control block
package sscw_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_MS = 1;
	localparam int MS_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int WORD_W = 16;
	localparam int NFOL = 6;
	// Control word bit positions
	localparam int B_OFF_A = 0;
	localparam int B_FOL = 2;
	localparam int B_SLEEP = 8;
	localparam int B_OFF_B = 9;
	localparam int B_RDLY = 10;
	localparam int B_WLEN = 12;
	localparam int B_OFF_C = 14;
	localparam int B_KICK = 15;
	localparam logic [15:0] CTRL_DEFAULT = 16'h4DFD;
	localparam logic [2:0] WD_ON_PAT = 3'h2;
	// Longest reset delay and window, in ms
	localparam logic [7:0] RDLY_MAX_MS = 8'h40;
	localparam logic [7:0] WLEN_MAX_MS = 8'h80;
	localparam int SETTLE_MS = 1;
	localparam logic [1:0] SETTLE_END = 2'(SETTLE_MS + 1);
	localparam logic [4:0] BIT_CNT_FULL = 5'h10;
	typedef enum logic [2:0] {
		WD_OFF = 3'b000,
		WD_CLOSED = 3'b001,
		WD_OPEN = 3'b010,
		WD_FAIL = 3'b011,
		WD_HOLD = 3'b100
	} sscw_wd_t;
endpackage : sscw_pkg

/* rtl/sscw_top.sv */
// Control word, status, reset delay and window watchdog logic
`timescale 1ns/1ps
`default_nettype none
module sscw_top
	import sscw_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC,
	parameter int N_FOL = NFOL
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_en,
	input wire logic main_below_3v3,
	input wire logic main_below_2v3,
	input wire logic second_below_1v4,
	input wire logic [2:0] rail_ok,
	input wire logic temp_warn,
	input wire logic temp_shutdown,
	input wire logic wake,
	input wire logic [N_FOL-1:0] follower_settled,
	input wire logic buck_on,
	output logic [N_FOL-1:0] sensor_follower_outputs,
	output logic reset_out_a_oe,
	output logic reset_out_b_oe,
	output logic reset_out_c_oe,
	output logic fault_n,
	output logic regulators_off
);
	localparam int NS = 11 + N_FOL;
	localparam logic [NS-1:0] SY_RST = NS'(1);

	logic [NS-1:0] sy1_r;
	logic [NS-1:0] sy2_r;
	logic cs_s;
	logic cs_d_r;
	logic frame_end;
	logic low33;
	logic low23;
	logic low14;
	logic [2:0] ok_s;
	logic tw_s;
	logic tsd_s;
	logic wake_s;
	logic dcdc_s;
	logic [N_FOL-1:0] settled_s;
	logic [WORD_W-1:0] rx_word;
	logic [WORD_W-1:0] stat_word;
	logic [WORD_W-1:0] stat_hold_r;
	logic [WORD_W-1:0] ctrl_r;
	logic kick;
	logic wd_en;
	logic [7:0] rdly_ms;
	logic [7:0] wlen_ctrl;
	logic [7:0] wlen_rx;
	logic [31:0] pre_r;
	logic tick_r;
	logic [2:0] rst_hold;
	logic [N_FOL-1:0] fol_fail;
	logic [N_FOL-1:0] fol_stat;
	logic cold_a_r;
	logic cold_b_r;
	logic err_cond;
	logic err_r;
	logic wd_err_r;
	logic wd_rst_r;
	logic wd_bad;
	logic wlast;
	logic hlast;
	sscw_wd_t state_r;
	logic [7:0] wcnt_r;
	logic [7:0] wlen_r;
	logic fault_n_r;
	logic regs_off_r;
	logic [N_FOL-1:0] fol_en_r;

	// Link side shifter on the serial clock
	sscw_link u_link (
		.sclk(sclk),
		.cs_n(cs_n),
		.serial_in(serial_in),
		.status_word(stat_hold_r),
		.serial_out(serial_out),
		.rx_word(rx_word)
	);

	// Output driven only while selected
	assign serial_out_en = ~cs_n;

	// Two-flop synchronisers for every pin input except ref_clk, resetn, sclk and serial_in
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			sy1_r <= SY_RST;
			sy2_r <= SY_RST;
		end
		else
		begin
			sy1_r <= {follower_settled, buck_on, wake, temp_shutdown, temp_warn, rail_ok,
				second_below_1v4, main_below_2v3, main_below_3v3, cs_n};
			sy2_r <= sy1_r;
		end
	end

	// Unpacked synchronised levels
	assign cs_s = sy2_r[0];
	assign low33 = sy2_r[1];
	assign low23 = sy2_r[2];
	assign low14 = sy2_r[3];
	assign ok_s = sy2_r[6:4];
	assign tw_s = sy2_r[7];
	assign tsd_s = sy2_r[8];
	assign wake_s = sy2_r[9];
	assign dcdc_s = sy2_r[10];
	assign settled_s = sy2_r[NS-1:11];

	// Select rise detection; word is stable once clock stopped
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			cs_d_r <= 1'b1;
		else
			cs_d_r <= cs_s;
	end
	assign frame_end = cs_s & ~cs_d_r;
	assign kick = frame_end & rx_word[B_KICK];

	// Status snapshot, frozen while a frame runs
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			stat_hold_r <= '0;
		else if (cs_s)
			stat_hold_r <= stat_word;
	end

	// Control word: defaults on reset or cold start
	always_ff @(posedge ref_clk)
	begin
		if (!resetn || low33)
			ctrl_r <= CTRL_DEFAULT;
		else if (frame_end)
			ctrl_r <= rx_word;
	end

	// Decoded settings
	assign wd_en = ({ctrl_r[B_OFF_A], ctrl_r[B_OFF_B], ctrl_r[B_OFF_C]} == WD_ON_PAT);
	assign rdly_ms = RDLY_MAX_MS >> ctrl_r[B_RDLY +: 2];
	assign wlen_ctrl = WLEN_MAX_MS >> ctrl_r[B_WLEN +: 2];
	assign wlen_rx = WLEN_MAX_MS >> rx_word[B_WLEN +: 2];

	// Millisecond tick prescaler
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			pre_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= (pre_r == 32'(MS_CYCLES - 1));
			if (pre_r == 32'(MS_CYCLES - 1))
				pre_r <= '0;
			else
				pre_r <= 32'(pre_r + 32'h1);
		end
	end

	// Per-rail reset delay sequencers
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_rst
			logic [7:0] cnt_r;
			logic hold_r;
			logic frc;
			assign frc = (gi == 0) && wd_rst_r;
			always_ff @(posedge ref_clk)
			begin
				if (!resetn || !ok_s[gi] || frc)
				begin
					cnt_r <= '0;
					hold_r <= 1'b1;
				end
				else if (hold_r && tick_r)
				begin
					if (cnt_r >= rdly_ms)
						hold_r <= 1'b0;
					else
						cnt_r <= 8'(cnt_r + 8'h01);
				end
			end
			assign rst_hold[gi] = hold_r;
		end
	endgenerate
	assign reset_out_a_oe = rst_hold[0];
	assign reset_out_b_oe = rst_hold[1];
	assign reset_out_c_oe = rst_hold[2];

	// Follower settling supervision after enable
	generate
		for (gi = 0; gi < N_FOL; gi++)
		begin : g_fol
			logic [1:0] scnt_r;
			logic fail_r;
			always_ff @(posedge ref_clk)
			begin
				if (!resetn || !fol_en_r[gi])
				begin
					scnt_r <= '0;
					fail_r <= 1'b0;
				end
				else if (scnt_r != SETTLE_END)
				begin
					if (settled_s[gi])
						scnt_r <= SETTLE_END;
					else if (tick_r)
					begin
						fail_r <= (scnt_r == SETTLE_END - 2'h1);
						scnt_r <= 2'(scnt_r + 2'h1);
					end
				end
			end
			assign fol_fail[gi] = fail_r;
			assign fol_stat[gi] = fol_en_r[gi] & settled_s[gi];
		end
	endgenerate

	// Follower enables driven from control bits
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			fol_en_r <= CTRL_DEFAULT[B_FOL +: N_FOL];
		else
			fol_en_r <= ctrl_r[B_FOL +: N_FOL];
	end
	assign sensor_follower_outputs = fol_en_r;

	// Memory retention flags; a drop beats the clear
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			cold_a_r <= 1'b1;
			cold_b_r <= 1'b1;
		end
		else
		begin
			if (low23)
				cold_a_r <= 1'b1;
			else if (frame_end)
				cold_a_r <= 1'b0;
			if (low14)
				cold_b_r <= 1'b1;
			else if (frame_end)
				cold_b_r <= 1'b0;
		end
	end

	// Error sources and latched error bit
	assign err_cond = tw_s | wd_err_r | cold_a_r | cold_b_r | (|fol_fail);
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			err_r <= 1'b0;
		else if (err_cond)
			err_r <= 1'b1;
		else if (frame_end)
			err_r <= 1'b0;
	end

	// Fault pin, low while any error stands
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			fault_n_r <= 1'b1;
		else
			fault_n_r <= ~(err_cond | err_r);
	end
	assign fault_n = fault_n_r;

	// Power down request and thermal shutdown
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			regs_off_r <= 1'b0;
		else
			regs_off_r <= (~ctrl_r[B_SLEEP] & ~wake_s) | tsd_s;
	end
	assign regulators_off = regs_off_r;

	// Window end and half-window end
	assign wlast = tick_r && (wcnt_r == 8'(wlen_r - 8'h01));
	assign hlast = tick_r && (wcnt_r == 8'((wlen_r >> 1) - 8'h01));
	assign wd_bad = wd_en && ((state_r == WD_CLOSED && kick) || (state_r == WD_OPEN && !kick && wlast));

	// Window watchdog sequencing
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			state_r <= WD_OFF;
			wcnt_r <= '0;
			wlen_r <= WLEN_MAX_MS;
			wd_rst_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				WD_OFF:
				begin
					wcnt_r <= '0;
					if (wd_en && !rst_hold[0])
					begin
						state_r <= WD_CLOSED;
						wlen_r <= wlen_ctrl;
					end
				end
				WD_CLOSED:
				begin
					if (!wd_en)
						state_r <= WD_OFF;
					else if (kick)
					begin
						state_r <= WD_FAIL;
						wcnt_r <= '0;
					end
					else if (wlast)
					begin
						state_r <= WD_OPEN;
						wcnt_r <= '0;
					end
					else if (tick_r)
						wcnt_r <= 8'(wcnt_r + 8'h01);
				end
				WD_OPEN:
				begin
					if (!wd_en)
						state_r <= WD_OFF;
					else if (kick)
					begin
						state_r <= WD_CLOSED;
						wlen_r <= wlen_rx;
						wcnt_r <= '0;
					end
					else if (wlast)
					begin
						state_r <= WD_FAIL;
						wcnt_r <= '0;
					end
					else if (tick_r)
						wcnt_r <= 8'(wcnt_r + 8'h01);
				end
				WD_FAIL:
				begin
					if (hlast)
					begin
						state_r <= WD_HOLD;
						wd_rst_r <= 1'b1;
					end
					else if (tick_r)
						wcnt_r <= 8'(wcnt_r + 8'h01);
				end
				WD_HOLD:
				begin
					if (rst_hold[0])
					begin
						wd_rst_r <= 1'b0;
						state_r <= WD_OFF;
					end
				end
				default:
					state_r <= WD_OFF;
			endcase
		end
	end

	// Watchdog error flag; a new failure beats the clear
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			wd_err_r <= 1'b0;
		else if (wd_bad)
			wd_err_r <= 1'b1;
		else if (frame_end)
			wd_err_r <= 1'b0;
	end

	// Status word assembly
	assign stat_word = {dcdc_s, wd_err_r, rst_hold, (state_r == WD_CLOSED),
		~cold_b_r, ~cold_a_r, fol_stat, tw_s, err_r};

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	chk_ctrl_load: assert property (frame_end && !low33 |=> ctrl_r == $past(rx_word))
		else $error("control word not loaded at select rise");
	chk_cold_default: assert property (low33 |=> ctrl_r == CTRL_DEFAULT)
		else $error("cold start did not restore defaults");
	chk_ram_clear: assert property (frame_end && !low23 |=> !cold_a_r)
		else $error("retention flag not cleared after transfer");
	chk_ram_set: assert property ($rose(low14) |=> cold_b_r && !stat_word[B_OFF_B])
		else $error("retention flag not set on rail drop");
	chk_fault_pin: assert property (err_cond |=> !fault_n ##1 (!fault_n || !err_r))
		else $error("fault pin not low on error");
	chk_wd_disable: assert property (state_r == WD_CLOSED && !wd_en |=> state_r == WD_OFF)
		else $error("watchdog kept running when disabled");
	chk_early_kick: assert property (state_r == WD_CLOSED && wd_en && kick |=> state_r == WD_FAIL && wd_err_r)
		else $error("early kick not flagged");
	chk_new_window: assert property (state_r == WD_OPEN && wd_en && kick |=> state_r == WD_CLOSED && wlen_r == $past(wlen_rx))
		else $error("kick did not restart window with new length");
	chk_start_delay: assert property (state_r == WD_OFF && rst_hold[0] |=> state_r != WD_CLOSED)
		else $error("closed window before reset delay ended");
	chk_rail_reset: assert property (!ok_s[1] |=> reset_out_b_oe [*2])
		else $error("reset released while rail low");
	chk_sleep_off: assert property (!ctrl_r[B_SLEEP] && !wake_s |=> regulators_off)
		else $error("sleep request ignored");
endmodule : sscw_top
`default_nettype wire

/* verification/sscw_host_model.sv */
// Host-side serial master model for the supply control link
`timescale 1ns/1ps
`default_nettype none
module sscw_host_model
(
	input wire logic serial_out,
	input wire logic serial_out_en,
	output logic sclk,
	output logic cs_n,
	output logic serial_in
);
	logic do_last;
	wire do_line;

	// Released data line shows the inverse of its last driven level
	always @(serial_out or serial_out_en)
	begin
		if (serial_out_en)
			do_last = serial_out;
	end
	assign do_line = serial_out_en ? serial_out : ~do_last;

	// Idle: deselected, link clock parked low
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
	end

	// One frame, LSB first, optional pause between 8-bit halves
	task automatic xfer(input logic [31:0] w, input int nbits, input logic split, output logic [15:0] rd);
		int i;
		cs_n = 1'b0;
		#250;
		for (i = 0; i < nbits; i++)
		begin
			serial_in = w[i];
			#40;
			sclk = 1'b1;
			if (i < 16)
				rd[i] = do_line;
			#40;
			sclk = 1'b0;
			if (split && i == 7)
				#400;
		end
		#40;
		cs_n = 1'b1;
		serial_in = ~serial_in;
		#400;
	endtask : xfer
endmodule : sscw_host_model
`default_nettype wire

/* verification/sscw_top_tb.sv */
// Self-checking bench for the supply serial control block
`timescale 1ns/1ps
`default_nettype none
module sscw_top_tb
	import sscw_pkg::*;
;
	logic ref_clk, resetn, main_below_3v3, main_below_2v3, second_below_1v4;
	logic temp_warn, temp_shutdown, wake, buck_on;
	logic [2:0] rail_ok;
	logic [5:0] follower_settled;
	logic [15:0] st;
	wire sclk, cs_n, serial_in, serial_out, serial_out_en, rst_a, rst_b, rst_c, fault_n, regulators_off;
	wire [5:0] fol_out;
	int mismatches = 0;
	int num_checks = 0;

	// Device under test with a short millisecond tick
	sscw_top #(.MS_CYCLES(20), .N_FOL(6)) dut (.ref_clk(ref_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
		.serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
		.main_below_3v3(main_below_3v3), .main_below_2v3(main_below_2v3), .second_below_1v4(second_below_1v4),
		.rail_ok(rail_ok), .temp_warn(temp_warn), .temp_shutdown(temp_shutdown), .wake(wake),
		.follower_settled(follower_settled), .buck_on(buck_on), .sensor_follower_outputs(fol_out),
		.reset_out_a_oe(rst_a), .reset_out_b_oe(rst_b), .reset_out_c_oe(rst_c), .fault_n(fault_n),
		.regulators_off(regulators_off));

	// Host on the link side
	sscw_host_model host (.serial_out(serial_out), .serial_out_en(serial_out_en), .sclk(sclk), .cs_n(cs_n),
		.serial_in(serial_in));

	// System clock
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic report_and_stop();
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	// Control word builder; wdp is {bit0, bit9, bit14}, delay and window index 3
	function automatic logic [15:0] cw(input logic [5:0] fol, input logic slp, input logic [2:0] wdp,
		input logic kick);
		logic [15:0] w;
		w = 16'h3C00;
		w[B_FOL+:6] = fol;
		w[B_SLEEP] = slp;
		w[B_OFF_A] = wdp[2];
		w[B_OFF_B] = wdp[1];
		w[B_OFF_C] = wdp[0];
		w[B_KICK] = kick;
		return w;
	endfunction : cw

	task automatic frame(input logic [15:0] w);
		host.xfer({16'h0000, w}, 16, 1'b0, st);
		@(posedge ref_clk);
	endtask : frame

	// Reset outputs held for the default delay after rails come up
	task automatic t_release();
		int i;
		chk(16'h003F, 16'(fol_out));
		rail_ok <= 3'h7;
		cyc(155);
		chk(16'h0007, 16'({rst_a, rst_b, rst_c}));
		for (i = 0; i < 60 && rst_a; i++)
			cyc(1);
		cyc(2);
		chk(16'h0000, 16'({rst_a, rst_b, rst_c}));
	endtask : t_release

	// Write, read back status, retention flags set and cleared
	task automatic t_frames();
		logic [15:0] w;
		w = cw(6'h2A, 1'b1, 3'h5, 1'b0);
		frame(w);
		chk(16'h80FC, st & 16'hFFFE);
		chk(16'h0000, 16'(serial_out_en));
		cyc(8);
		chk(16'h002A, 16'(fol_out));
		frame(w);
		chk(16'h83A8, st & 16'hFFFE);
		cyc(8);
		chk(16'h0001, 16'(fault_n));
		main_below_2v3 <= 1'b1;
		cyc(4);
		main_below_2v3 <= 1'b0;
		cyc(4);
		frame(w);
		chk(16'h0200, st & 16'h0300);
	endtask : t_frames

	// Two 8-bit halves, then a 32-bit daisy-chain frame
	task automatic t_chain();
		host.xfer({16'h0000, cw(6'h0F, 1'b1, 3'h5, 1'b0)}, 16, 1'b1, st);
		cyc(8);
		chk(16'h000F, 16'(fol_out));
		host.xfer({cw(6'h33, 1'b1, 3'h5, 1'b0), 16'h0000}, 32, 1'b0, st);
		cyc(8);
		chk(16'h0033, 16'(fol_out));
	endtask : t_chain

	// Temperature warning raises error, fault pin and flag
	task automatic t_temp();
		temp_warn <= 1'b1;
		cyc(6);
		chk(16'h0000, 16'(fault_n));
		frame(cw(6'h33, 1'b1, 3'h5, 1'b0));
		chk(16'h0003, st & 16'h0003);
		temp_warn <= 1'b0;
		frame(cw(6'h33, 1'b1, 3'h5, 1'b0));
		frame(cw(6'h33, 1'b1, 3'h5, 1'b0));
		chk(16'h0000, st & 16'h0003);
		cyc(8);
		chk(16'h0001, 16'(fault_n));
	endtask : t_temp

	// Sleep only takes effect while wake is low
	task automatic t_sleep();
		wake <= 1'b1;
		frame(cw(6'h33, 1'b0, 3'h5, 1'b0));
		cyc(8);
		chk(16'h0000, 16'(regulators_off));
		wake <= 1'b0;
		cyc(8);
		chk(16'h0001, 16'(regulators_off));
		frame(cw(6'h33, 1'b1, 3'h5, 1'b0));
		cyc(8);
		chk(16'h0000, 16'(regulators_off));
	endtask : t_sleep

	// Off pattern, enable, early kick, then delayed reset
	task automatic t_watchdog();
		logic [15:0] w;
		int i;
		frame(cw(6'h33, 1'b1, 3'h0, 1'b0));
		frame(cw(6'h33, 1'b1, 3'h0, 1'b0));
		chk(16'h0000, 16'(st[10]));
		cyc(60);
		w = cw(6'h33, 1'b1, 3'h2, 1'b0);
		frame(w);
		frame(w);
		chk(16'h0001, 16'(st[10]));
		chk(16'h0001, 16'(fault_n));
		w[B_KICK] = 1'b1;
		frame(w);
		cyc(6);
		chk(16'h0000, 16'(fault_n));
		cyc(120);
		chk(16'h0000, 16'(rst_a));
		for (i = 0; i < 60 && !rst_a; i++)
			cyc(1);
		chk(16'h0001, 16'(rst_a));
		frame(cw(6'h33, 1'b1, 3'h2, 1'b0));
		chk(16'h4800, st & 16'h4800);
	endtask : t_watchdog

	// Written settings hold, cold start restores defaults
	task automatic t_cold();
		frame(cw(6'h0F, 1'b1, 3'h5, 1'b0));
		cyc(30);
		chk(16'h000F, 16'(fol_out));
		main_below_3v3 <= 1'b1;
		cyc(6);
		main_below_3v3 <= 1'b0;
		cyc(8);
		chk(16'h003F, 16'(fol_out));
	endtask : t_cold

	// Kick in the open window restarts the closed one; a missing kick fails
	task automatic t_window();
		logic [15:0] w;
		int i;
		for (i = 0; i < 300 && rst_a; i++)
			cyc(1);
		w = cw(6'h3F, 1'b1, 3'h2, 1'b0);
		frame(w);
		cyc(340);
		frame(w);
		chk(16'h0000, 16'(st[10]));
		w[B_KICK] = 1'b1;
		frame(w);
		w[B_KICK] = 1'b0;
		frame(w);
		chk(16'h0001, 16'(st[10]));
		chk(16'h0001, 16'(fault_n));
		cyc(700);
		chk(16'h0000, 16'(fault_n));
	endtask : t_window

	// Retention flag B, unsettled follower and thermal shutdown
	task automatic t_faults();
		second_below_1v4 <= 1'b1;
		cyc(4);
		second_below_1v4 <= 1'b0;
		cyc(4);
		frame(cw(6'h3E, 1'b1, 3'h5, 1'b0));
		chk(16'h0100, st & 16'h0300);
		follower_settled <= 6'h3E;
		frame(cw(6'h3F, 1'b1, 3'h5, 1'b0));
		cyc(50);
		chk(16'h0000, 16'(fault_n));
		frame(cw(6'h3F, 1'b1, 3'h5, 1'b0));
		chk(16'h00F9, st & 16'h00FF);
		temp_shutdown <= 1'b1;
		cyc(6);
		chk(16'h0001, 16'(regulators_off));
		temp_shutdown <= 1'b0;
		cyc(6);
		chk(16'h0000, 16'(regulators_off));
	endtask : t_faults

	// Stimulus defaults, reset and scenario sequence
	initial
	begin
		resetn = 1'b0;
		main_below_3v3 = 1'b0;
		main_below_2v3 = 1'b0;
		second_below_1v4 = 1'b0;
		temp_warn = 1'b0;
		temp_shutdown = 1'b0;
		wake = 1'b0;
		buck_on = 1'b1;
		rail_ok = 3'h0;
		follower_settled = 6'h3F;
		cyc(6);
		resetn <= 1'b1;
		cyc(4);
		t_release();
		t_frames();
		t_chain();
		t_temp();
		t_sleep();
		t_watchdog();
		t_cold();
		t_window();
		t_faults();
		report_and_stop();
	end

	// Hang guard, well beyond the expected run length
	initial
	begin
		cyc(6000);
		mismatches++;
		report_and_stop();
	end
endmodule : sscw_top_tb
`default_nettype wire
